// [core/opl_delay_filter.sv]
// assertion/deassertion delay filter for one output pin
// assumes a one-cycle millisecond tick on the same clock
`timescale 1ns/1ps
module opl_delay_filter
  import opl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  opl_filt_if.filt port
);
  logic out_q;
  logic last_q;
  opl_ms_t stable_q;
  opl_ms_t need;

  assign need = port.rawLevel ? port.onMs : port.offMs;
  assign port.filtLevel = out_q;

  // time since the input last moved, saturating
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      last_q <= 1'b0;
      stable_q <= '0;
    end
    else
    begin
      last_q <= port.rawLevel;
      if (port.rawLevel != last_q)
        stable_q <= '0;
      else if (port.msTick && stable_q != 12'hfff)
        stable_q <= stable_q + 12'h001;
    end
  end

  // output moves only after the input held still for the full delay
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      out_q <= 1'b0;
    else if (port.rawLevel != out_q && port.rawLevel == last_q &&
             stable_q >= need)
      out_q <= port.rawLevel;
  end
endmodule

// [core/opl_filt_if.sv]
// carrier between the pin logic and one delay filter
// assumes one instance per output pin
`timescale 1ns/1ps
interface opl_filt_if;
  import opl_pkg::*;
  logic msTick;
  logic rawLevel;
  opl_ms_t onMs;
  opl_ms_t offMs;
  logic filtLevel;
  modport filt (input msTick, input rawLevel, input onMs, input offMs,
    output filtLevel);
  modport user (output msTick, output rawLevel, output onMs,
    output offMs, input filtLevel);
endinterface

// [core/opl_map.svh]
// register offsets, field positions, reset values and timing figures
// included by the output-pin block and its package users
`ifndef OPL_MAP_SVH
`define OPL_MAP_SVH

// command codes
`define OPL_CMD_SEQ_WAIT_LIMIT 8'he6
`define OPL_CMD_PIN_CONFIG 8'he7

// page ranges: sequencing channels 0..11, pins on pages 12..19
`define OPL_SEQ_PAGE_BASE 8'h00
`define OPL_PIN_PAGE_BASE 8'h0c
`define OPL_FAULT_LINE_PIN 3'h7

// reset values
`define OPL_SEQ_WAIT_RESET 16'h0000
`define OPL_PIN_CONFIG_RESET 32'h0000_0000
`define OPL_PIN_CONFIG_WMASK 32'hffff_ffc7

// pin configuration fields
`define OPL_F_MASK_HI 31
`define OPL_F_MASK_LO 16
`define OPL_F_OFF_HI 15
`define OPL_F_OFF_LO 12
`define OPL_F_ON_HI 11
`define OPL_F_ON_LO 8
`define OPL_F_DRIVE 7
`define OPL_F_POLARITY 6
`define OPL_F_FUNC_HI 2
`define OPL_F_FUNC_LO 0

// function codes
`define OPL_FN_MARGIN 3'h0
`define OPL_FN_FORCE_ON 3'h1
`define OPL_FN_FORCE_OFF 3'h2
`define OPL_FN_GOOD_AND 3'h3
`define OPL_FN_ALARM_OR 3'h4
`define OPL_FN_FAULT_LINE 3'h5

// timing
`define OPL_CLK_MHZ 200
`define OPL_TICK_MS 1

// delay code to milliseconds
`define OPL_DLY_0 12'd0
`define OPL_DLY_1 12'd5
`define OPL_DLY_2 12'd10
`define OPL_DLY_3 12'd20
`define OPL_DLY_4 12'd40
`define OPL_DLY_5 12'd60
`define OPL_DLY_6 12'd80
`define OPL_DLY_7 12'd100
`define OPL_DLY_8 12'd200
`define OPL_DLY_9 12'd400
`define OPL_DLY_10 12'd600
`define OPL_DLY_11 12'd800
`define OPL_DLY_12 12'd1000
`define OPL_DLY_13 12'd1500
`define OPL_DLY_14 12'd2000
`define OPL_DLY_15 12'd4000

`endif

// [core/opl_output_pins.sv]
// output-pin logic and sequencing wait-limit timers
// assumes command decode upstream presents one command per cmdValid
// Operation
// - time ms from chosen group start to channel start event, compare.
// - wait limit is a two-byte direct value; zero disables the check.
// - on timeout set status-word output summary and wait-fault bit.
// - on timeout request fault action; alert only if alerting enabled.
// - configuration applies per pin, eight pins, outputs 0-7 or 12-19.
// - function 000 drives the margining waveform onto the pin.
// - function 001 forces asserted, 010 forces deasserted.
// - function 011 asserts when all masked channels report good.
// - function 100 asserts when any masked channel alarm is active.
// - mask bit number equals channel number plus 16.
// - mask and delays matter only in functions 011 and 100.
// - four-bit deassert delay code picks 0 to 4000 ms.
// - each pin has own polarity and drive-type selection.
// - bits 11:8 pick assert delay from the same table.
// - output changes only after input is stable for the whole delay.
// - function 101 is the fault-line function on pin 7; 11x reserved.
// - bit 7 push-pull 0 / open-drain 1; bit 6 low 0 / high 1.
`timescale 1ns/1ps
`include "opl_map.svh"
module opl_output_pins
  import opl_pkg::*;
#(
  parameter int NPIN = 8,
  parameter int NSEQ = 12,
  parameter int NCHAN = 16,
  parameter int TICK_CYCLES = `OPL_TICK_MS * 1000 * `OPL_CLK_MHZ
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] cmdPage,
  input wire logic [31:0] cmdWdata,
  output logic [31:0] cmdRdata,
  output logic cmdAck,
  output logic cmdErr,
  input wire logic [NCHAN-1:0] goodOrInputPin,
  input wire logic [NCHAN-1:0] chanAlarm,
  input wire logic [NPIN-1:0] marginWave,
  input wire logic faultLineLevel,
  input wire logic sequenceGroupZero,
  input wire logic sequenceGroupOne,
  input wire logic [NSEQ-1:0] groupChoiceBit,
  input wire logic [NSEQ-1:0] chanStartEvent,
  input wire logic alertEnable,
  input wire logic clearFaults,
  output logic [NPIN-1:0] pinOut,
  output logic [NPIN-1:0] pinOe,
  output logic statusWordVout,
  output logic [NSEQ-1:0] sequenceWaitFault,
  output logic [NSEQ-1:0] faultActionReq,
  output logic alertOut,
  output logic alertOe
);

  function automatic opl_ms_t dlyMs(input logic [3:0] code);
    opl_ms_t r;
    r = `OPL_DLY_0;
    unique case (code)
      4'h0: r = `OPL_DLY_0;
      4'h1: r = `OPL_DLY_1;
      4'h2: r = `OPL_DLY_2;
      4'h3: r = `OPL_DLY_3;
      4'h4: r = `OPL_DLY_4;
      4'h5: r = `OPL_DLY_5;
      4'h6: r = `OPL_DLY_6;
      4'h7: r = `OPL_DLY_7;
      4'h8: r = `OPL_DLY_8;
      4'h9: r = `OPL_DLY_9;
      4'ha: r = `OPL_DLY_10;
      4'hb: r = `OPL_DLY_11;
      4'hc: r = `OPL_DLY_12;
      4'hd: r = `OPL_DLY_13;
      4'he: r = `OPL_DLY_14;
      4'hf: r = `OPL_DLY_15;
    endcase
    return r;
  endfunction

  // millisecond tick
  logic [31:0] tickCnt_q;
  logic msTick_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tickCnt_q <= '0;
      msTick_q <= 1'b0;
    end
    else if (tickCnt_q == 32'(TICK_CYCLES - 1))
    begin
      tickCnt_q <= '0;
      msTick_q <= 1'b1;
    end
    else
    begin
      tickCnt_q <= tickCnt_q + 32'h0000_0001;
      msTick_q <= 1'b0;
    end
  end

  // good/input levels come from pins; two flops before use
  logic [NCHAN-1:0] goodMeta_q;
  logic [NCHAN-1:0] goodSync_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      goodMeta_q <= '0;
      goodSync_q <= '0;
    end
    else
    begin
      goodMeta_q <= goodOrInputPin;
      goodSync_q <= goodMeta_q;
    end
  end

  // command decode
  logic seqHit;
  logic pinHit;
  logic [7:0] seqIdx;
  logic [7:0] pinIdx;

  assign seqIdx = cmdPage - `OPL_SEQ_PAGE_BASE;
  assign pinIdx = cmdPage - `OPL_PIN_PAGE_BASE;
  assign seqHit = cmdCode == `OPL_CMD_SEQ_WAIT_LIMIT &&
                  seqIdx < 8'(NSEQ);
  assign pinHit = cmdCode == `OPL_CMD_PIN_CONFIG &&
                  cmdPage >= `OPL_PIN_PAGE_BASE && pinIdx < 8'(NPIN);

  logic [15:0] waitLimit_q [NSEQ];
  logic [31:0] pinCfg_q [NPIN];

  // read data and answer registered; unmapped code or page flags an error
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmdRdata <= '0;
      cmdAck <= 1'b0;
      cmdErr <= 1'b0;
    end
    else
    begin
      cmdAck <= cmdValid;
      cmdErr <= cmdValid && !seqHit && !pinHit;
      if (cmdValid && !cmdWrite)
      begin
        if (seqHit)
          cmdRdata <= {16'h0000, waitLimit_q[seqIdx[3:0]]};
        else if (pinHit)
          cmdRdata <= pinCfg_q[pinIdx[2:0]];
        else
          cmdRdata <= '0;
      end
    end
  end

  // sequencing wait timers, one per sequencing channel
  logic [NSEQ-1:0] timeout;

  genvar c;
  generate
    for (c = 0; c < NSEQ; c++)
    begin : g_seq
      opl_seq_state_t state_q;
      logic [15:0] elapsed_q;
      logic groupGo;

      assign groupGo = groupChoiceBit[c] ? sequenceGroupOne
                                         : sequenceGroupZero;

      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          waitLimit_q[c] <= `OPL_SEQ_WAIT_RESET;
        else if (cmdValid && cmdWrite && seqHit && seqIdx == 8'(c))
          waitLimit_q[c] <= cmdWdata[15:0];
      end

      // zero limit never trips
      assign timeout[c] = state_q == SEQ_WAIT &&
                          waitLimit_q[c] != 16'h0000 &&
                          elapsed_q > waitLimit_q[c];

      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          state_q <= SEQ_IDLE;
          elapsed_q <= '0;
        end
        else
        begin
          unique case (state_q)
            SEQ_IDLE:
            begin
              elapsed_q <= '0;
              if (groupGo)
                state_q <= SEQ_WAIT;
            end
            SEQ_WAIT:
            begin
              if (msTick_q && elapsed_q != 16'hffff)
                elapsed_q <= elapsed_q + 16'h0001;
              if (chanStartEvent[c] || timeout[c])
                state_q <= SEQ_DONE;
              else if (!groupGo)
                state_q <= SEQ_IDLE;
            end
            SEQ_DONE:
            begin
              if (!groupGo)
                state_q <= SEQ_IDLE;
            end
          endcase
        end
      end

      // set wins over clear
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          sequenceWaitFault[c] <= 1'b0;
        else if (timeout[c])
          sequenceWaitFault[c] <= 1'b1;
        else if (clearFaults)
          sequenceWaitFault[c] <= 1'b0;
      end

      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          faultActionReq[c] <= 1'b0;
        else
          faultActionReq[c] <= timeout[c];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      statusWordVout <= 1'b0;
    else if (|timeout)
      statusWordVout <= 1'b1;
    else if (clearFaults)
      statusWordVout <= 1'b0;
  end

  // alert is open-drain: pulled low while held
  logic alertHold_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      alertHold_q <= 1'b0;
    else if (|timeout && alertEnable)
      alertHold_q <= 1'b1;
    else if (clearFaults)
      alertHold_q <= 1'b0;
  end

  assign alertOut = 1'b0;
  assign alertOe = alertHold_q;

  // output pins
  genvar p;
  generate
    for (p = 0; p < NPIN; p++)
    begin : g_pin
      opl_filt_if fif ();
      opl_func_code_t func;
      logic [NCHAN-1:0] mask;
      logic useDelay;
      logic rawAssert;
      logic asserted;
      logic level;

      // reserved bits 5:3 are not stored and read back zero
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          pinCfg_q[p] <= `OPL_PIN_CONFIG_RESET;
        else if (cmdValid && cmdWrite && pinHit && pinIdx == 8'(p))
          pinCfg_q[p] <= cmdWdata & `OPL_PIN_CONFIG_WMASK;
      end

      assign func = pinCfg_q[p][`OPL_F_FUNC_HI:`OPL_F_FUNC_LO];
      assign mask = pinCfg_q[p][`OPL_F_MASK_HI:`OPL_F_MASK_LO];
      assign useDelay = func == `OPL_FN_GOOD_AND ||
                        func == `OPL_FN_ALARM_OR;

      always_comb
      begin
        rawAssert = 1'b0;
        unique case (func)
          `OPL_FN_FORCE_ON: rawAssert = 1'b1;
          `OPL_FN_FORCE_OFF: rawAssert = 1'b0;
          `OPL_FN_GOOD_AND: rawAssert = &(goodSync_q | ~mask);
          `OPL_FN_ALARM_OR: rawAssert = |(chanAlarm & mask);
          `OPL_FN_FAULT_LINE:
            rawAssert = (p == `OPL_FAULT_LINE_PIN) && faultLineLevel;
          default: rawAssert = 1'b0;
        endcase
      end

      // delays forced to zero outside the two logic modes
      assign fif.msTick = msTick_q;
      assign fif.rawLevel = rawAssert;
      assign fif.onMs = useDelay ?
        dlyMs(pinCfg_q[p][`OPL_F_ON_HI:`OPL_F_ON_LO]) : '0;
      assign fif.offMs = useDelay ?
        dlyMs(pinCfg_q[p][`OPL_F_OFF_HI:`OPL_F_OFF_LO]) : '0;

      opl_delay_filter u_filt (
        .clk(clk),
        .rst_b(rst_b),
        .port(fif.filt)
      );

      // margining waveform bypasses the filter and the polarity
      assign asserted = fif.filtLevel;
      assign level = pinCfg_q[p][`OPL_F_POLARITY] ? asserted
                                                  : !asserted;

      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          pinOut[p] <= 1'b0;
          pinOe[p] <= 1'b0;
        end
        else if (func == `OPL_FN_MARGIN)
        begin
          pinOut[p] <= marginWave[p];
          pinOe[p] <= 1'b1;
        end
        else if (pinCfg_q[p][`OPL_F_DRIVE])
        begin
          pinOut[p] <= 1'b0;
          pinOe[p] <= !level;
        end
        else
        begin
          pinOut[p] <= level;
          pinOe[p] <= 1'b1;
        end
      end
    end
  endgenerate

  // a rewrite during margining takes effect at once; host must avoid it
endmodule

// [core/opl_pkg.sv]
// types shared by the output-pin block
// assumes opl_map.svh supplies the numeric constants
package opl_pkg;
  typedef logic [2:0] opl_func_code_t;
  typedef logic [11:0] opl_ms_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT, SEQ_DONE} opl_seq_state_t;
endpackage

// [sim/opl_host_model.sv]
// host command master for the output-pin block
// assumes each command is answered one cycle after it is taken
`timescale 1ns/1ps
module opl_host_model
(
  input wire logic clk,
  input wire logic cmdAck,
  input wire logic cmdErr,
  input wire logic [31:0] cmdRdata,
  output logic cmdValid,
  output logic cmdWrite,
  output logic [7:0] cmdCode,
  output logic [7:0] cmdPage,
  output logic [31:0] cmdWdata
);
  initial
  begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    cmdPage = 8'h00;
    cmdWdata = 32'h0000_0000;
  end
  // caller enters just after an edge; code, page and data inverted once released
  task automatic xfer(input logic w, input logic [7:0] c,
    input logic [7:0] p, input logic [31:0] d, output logic [31:0] rd,
    output logic ak, output logic er);
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdCode = c;
    cmdPage = p;
    cmdWdata = d;
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    cmdCode = ~c;
    cmdPage = ~p;
    cmdWdata = ~d;
    rd = cmdRdata;
    ak = cmdAck;
    er = cmdErr;
  endtask
endmodule

// [sim/opl_output_pins_props.sv]
// assertions on the output-pin block ports
// assumes binding into opl_output_pins; pin 0 and channel 1 tracked
`timescale 1ns/1ps
module opl_output_pins_props
#(
  parameter int NPIN = 8,
  parameter int NSEQ = 12
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] cmdPage,
  input wire logic [31:0] cmdWdata,
  input wire logic cmdAck,
  input wire logic cmdErr,
  input wire logic [NPIN-1:0] marginWave,
  input wire logic alertEnable,
  input wire logic [NPIN-1:0] pinOut,
  input wire logic [NPIN-1:0] pinOe,
  input wire logic statusWordVout,
  input wire logic [NSEQ-1:0] sequenceWaitFault,
  input wire logic [NSEQ-1:0] faultActionReq,
  input wire logic alertOe
);
  logic [31:0] cfg_q;
  logic [15:0] lim_q;
  logic [2:0] cfgAge_q;
  logic [2:0] limAge_q;
  logic cfgWr;
  logic limWr;
  assign cfgWr = cmdValid && cmdWrite && cmdCode == 8'he7 &&
    cmdPage == 8'h0c;
  assign limWr = cmdValid && cmdWrite && cmdCode == 8'he6 &&
    cmdPage == 8'h01;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      cfg_q <= 32'h0000_0000;
    else if (cfgWr)
      cfg_q <= cmdWdata;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      lim_q <= 16'h0000;
    else if (limWr)
      lim_q <= cmdWdata[15:0];
  // ages saturate: the design needs a few cycles before a write shows
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      cfgAge_q <= 3'h0;
    else if (cfgWr)
      cfgAge_q <= 3'h0;
    else if (cfgAge_q != 3'h7)
      cfgAge_q <= cfgAge_q + 3'h1;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      limAge_q <= 3'h0;
    else if (limWr)
      limAge_q <= 3'h0;
    else if (limAge_q != 3'h7)
      limAge_q <= limAge_q + 3'h1;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_cfgSettled;
    cfgAge_q == 3'h7;
  endsequence
  sequence s_faultSet;
    $rose(sequenceWaitFault[0]);
  endsequence
  a_err_unmapped: assert property (
    cmdValid && cmdPage > 8'h13 |=> cmdAck && cmdErr)
    else $error("unmapped page not refused");
  a_margin_pass: assert property (
    s_cfgSettled ##0 cfg_q[2:0] == 3'h0 |->
      pinOut[0] == $past(marginWave[0]) && pinOe[0])
    else $error("margin waveform not on pin 0");
  a_force_level: assert property (
    s_cfgSettled ##0 (cfg_q[2:0] == 3'h1 || cfg_q[2:0] == 3'h2) |->
      (pinOe[0] ? pinOut[0] : 1'b1) == (cfg_q[6] ^ cfg_q[1]))
    else $error("forced level wrong on pin 0");
  a_push_pull: assert property (
    s_cfgSettled ##0 cfg_q[2:0] != 3'h0 && !cfg_q[7] |-> pinOe[0])
    else $error("push-pull pin 0 not driven");
  a_wait_flags: assert property (
    s_faultSet |-> statusWordVout && faultActionReq[0])
    else $error("timeout flags incomplete");
  a_req_pulse: assert property (
    faultActionReq[0] |=> !faultActionReq[0])
    else $error("fault action request not a pulse");
  a_alert_gate: assert property (
    $rose(alertOe) |-> $past(alertEnable) && |faultActionReq)
    else $error("alert without enabled timeout");
  a_zero_limit: assert property (
    limAge_q == 3'h7 && lim_q == 16'h0000 |-> !faultActionReq[1])
    else $error("disabled limit raised a fault");
endmodule

bind opl_output_pins opl_output_pins_props #(.NPIN(NPIN), .NSEQ(NSEQ))
  u_props (.clk, .rst_b, .cmdValid, .cmdWrite, .cmdCode, .cmdPage,
  .cmdWdata, .cmdAck, .cmdErr, .marginWave, .alertEnable, .pinOut, .pinOe,
  .statusWordVout, .sequenceWaitFault, .faultActionReq, .alertOe);

// [sim/opl_output_pins_tb.sv]
// self-checking bench for the output-pin block
// assumes opl_host_model drives commands and the checker is bound in
`timescale 1ns/1ps
`define CHK(n, e, s) chk(n, 64'(e), 64'(s))
module opl_output_pins_tb;
  localparam int TK = 10;
  localparam int MS [16] = '{0, 5, 10, 20, 40, 60, 80, 100, 200, 400,
    600, 800, 1000, 1500, 2000, 4000};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmdValid;
  logic cmdWrite;
  logic [7:0] cmdCode;
  logic [7:0] cmdPage;
  logic [31:0] cmdWdata;
  logic [31:0] cmdRdata;
  logic cmdAck;
  logic cmdErr;
  logic [15:0] goodOrInputPin = 16'h0000;
  logic [15:0] chanAlarm = 16'h0000;
  logic [7:0] marginWave = 8'h00;
  logic faultLineLevel = 1'b0;
  logic sequenceGroupZero = 1'b0;
  logic sequenceGroupOne = 1'b0;
  logic [11:0] groupChoiceBit = 12'h000;
  logic [11:0] chanStartEvent = 12'h000;
  logic alertEnable = 1'b0;
  logic clearFaults = 1'b0;
  logic [7:0] pinOut;
  logic [7:0] pinOe;
  logic statusWordVout;
  logic [11:0] sequenceWaitFault;
  logic [11:0] faultActionReq;
  logic alertOut;
  logic alertOe;
  logic [31:0] seed = 32'h0000_7f63;
  int bad_count = 0;
  int n_compared = 0;
  always #2.5 clk = ~clk;
  opl_host_model host (.clk, .cmdAck, .cmdErr, .cmdRdata, .cmdValid,
    .cmdWrite, .cmdCode, .cmdPage, .cmdWdata);
  opl_output_pins #(.TICK_CYCLES(TK)) uut (.clk, .rst_b, .cmdValid,
    .cmdWrite, .cmdCode, .cmdPage, .cmdWdata, .cmdRdata, .cmdAck, .cmdErr,
    .goodOrInputPin, .chanAlarm, .marginWave, .faultLineLevel,
    .sequenceGroupZero, .sequenceGroupOne, .groupChoiceBit,
    .chanStartEvent, .alertEnable, .clearFaults, .pinOut, .pinOe,
    .statusWordVout, .sequenceWaitFault, .faultActionReq, .alertOut,
    .alertOe);
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic level(input logic [2:0] f, input logic pol);
    return pol ^ (f == 3'h2);
  endfunction
  // open-drain pins are read through a pull-up
  function automatic logic pw(input int p);
    return pinOe[p] ? pinOut[p] : 1'b1;
  endfunction
  task automatic chk(input string n, input logic [63:0] e,
    input logic [63:0] s);
    n_compared++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmd(input logic w, input logic [7:0] c,
    input logic [7:0] p, input logic [31:0] d, input logic [31:0] e,
    input logic eErr);
    logic [31:0] rd;
    logic ak;
    logic er;
    host.xfer(w, c, p, d, rd, ak, er);
    `CHK("ack", 1'b1, ak);
    `CHK("err", eErr, er);
    if (!w)
      `CHK("rdata", e, rd);
    cyc(1);
  endtask
  task automatic settle(input string n, input int p, input int ms,
    input logic lv);
    if (ms > 0)
    begin
      cyc((ms - 1) * TK);
      `CHK(n, !lv, pw(p));
    end
    cyc(TK + 15);
    `CHK(n, lv, pw(p));
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  initial
  begin
    logic [31:0] d;
    logic [3:0] onC;
    logic [3:0] offC;
    cyc(1);
    `CHK("rst_oe", 8'h00, pinOe);
    cyc(1);
    rst_b = 1'b1;
    for (int p = 0; p < 12; p++)
    begin
      seed = lfsr(seed);
      cmd(1'b1, 8'he6, 8'(p), seed, 32'h0, 1'b0);
      cmd(1'b0, 8'he6, 8'(p), 32'h0, {16'h0000, seed[15:0]}, 1'b0);
      if (p < 8)
      begin
        cmd(1'b1, 8'he7, 8'(p + 12), seed, 32'h0, 1'b0);
        cmd(1'b0, 8'he7, 8'(p + 12), 32'h0, seed & 32'hffff_ffc7, 1'b0);
      end
    end
    cmd(1'b0, 8'he7, 8'h14, 32'h0, 32'h0, 1'b1);
    cmd(1'b0, 8'he6, 8'h0c, 32'h0, 32'h0, 1'b1);
    for (int i = 0; i < 64; i++)
    begin
      // longest delay codes: forced modes must ignore them
      d = {16'h0, 8'hff, i[0], i[1], 3'h0, 3'h1 + 3'(i[2])};
      cmd(1'b1, 8'he7, 8'h0c + 8'(i[5:3]), d, 32'h0, 1'b0);
      cyc(4);
      `CHK("force", level(d[2:0], d[6]), pw(i[5:3]));
      if (!d[7])
        `CHK("drive", 1'b1, pinOe[i[5:3]]);
    end
    cmd(1'b1, 8'he7, 8'h0c, 32'h0, 32'h0, 1'b0);
    cyc(4);
    repeat (20)
    begin
      seed = lfsr(seed);
      marginWave = seed[7:0];
      faultLineLevel = seed[8];
      cyc(1);
      `CHK("margin", marginWave[0], pinOut[0]);
      `CHK("margin_oe", 1'b1, pinOe[0]);
    end
    seed = lfsr(seed);
    onC = 4'h1 + {2'b00, seed[1:0]};
    offC = {2'b00, seed[3:2]};
    goodOrInputPin = (seed[31:16] & 16'hffde) | 16'h0001;
    cmd(1'b1, 8'he7, 8'h0c, {16'h0021, offC, onC, 8'h43}, 32'h0, 1'b0);
    cyc(MS[offC] * TK + 20);
    `CHK("and_idle", 1'b0, pw(0));
    goodOrInputPin[5] = 1'b1;
    cyc((MS[onC] - 1) * TK);
    goodOrInputPin[5] = 1'b0;
    cyc(1);
    goodOrInputPin[5] = 1'b1;
    settle("and_on", 0, MS[onC], 1'b1);
    goodOrInputPin[0] = 1'b0;
    settle("and_off", 0, MS[offC], 1'b0);
    onC = {2'b00, seed[5:4]};
    cmd(1'b1, 8'he7, 8'h0e, {16'h0008, 4'h0, onC, 8'h04}, 32'h0, 1'b0);
    chanAlarm = seed[31:16] & 16'hfff7;
    cyc(40);
    `CHK("or_blocked", 1'b1, pw(2));
    chanAlarm[3] = 1'b1;
    settle("or_on", 2, MS[onC], 1'b0);
    // fault line on pin 7 only; pin 6 refuses it, code 110 is reserved
    cmd(1'b1, 8'he7, 8'h13, 32'h0000_ff45, 32'h0, 1'b0);
    cmd(1'b1, 8'he7, 8'h12, 32'h0000_0045, 32'h0, 1'b0);
    cmd(1'b1, 8'he7, 8'h11, 32'h0000_0006, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      faultLineLevel = i[0];
      cyc(6);
      `CHK("fault_line", i[0], pw(7));
      `CHK("fault_other", 1'b0, pw(6));
      `CHK("reserved", 1'b1, pw(5));
    end
    for (int p = 0; p < 12; p++)
      cmd(1'b1, 8'he6, 8'(p), p == 2 ? 32'h8 : (p % 3 == 0 ? 32'h3 : 32'h0),
        32'h0, 1'b0);
    groupChoiceBit = 12'h008;
    alertEnable = 1'b1;
    sequenceGroupZero = 1'b1;
    sequenceGroupOne = 1'b1;
    cyc(3 * TK);
    `CHK("wait_early", 12'h000, sequenceWaitFault);
    cyc(2 * TK);
    chanStartEvent[2] = 1'b1;
    cyc(TK);
    `CHK("wait_fault", 12'h249, sequenceWaitFault);
    `CHK("vout", 1'b1, statusWordVout);
    `CHK("alert", 1'b1, alertOe);
    `CHK("alert_pin", 1'b0, alertOut);
    cyc(6 * TK);
    `CHK("started", 12'h249, sequenceWaitFault);
    sequenceGroupZero = 1'b0;
    sequenceGroupOne = 1'b0;
    clearFaults = 1'b1;
    cyc(1);
    clearFaults = 1'b0;
    alertEnable = 1'b0;
    cyc(2);
    `CHK("cleared", 12'h000, sequenceWaitFault);
    sequenceGroupZero = 1'b1;
    cyc(6 * TK);
    `CHK("group_zero", 12'h241, sequenceWaitFault);
    `CHK("no_alert", 1'b0, alertOe);
    stop_test();
  end
endmodule
